// *** rtl/sci_rx_status.sv ***
// serial receiver with status flags, standby wakeup and apb registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module sci_rx_status (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        break_state,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  output logic             rx_irq,
  output logic             err_irq,
  output logic             wait_wakeup
);

  rx_link_if lnk ();

  // ==========================================================================
  // registers and state
  logic [4:0]  ctrl1_q;
  logic [3:0]  ctrl2_q;
  logic [3:0]  ctrl3_q;
  logic        r8_q;
  logic        bce_q;
  logic [15:0] baud_q;
  logic [7:0]  data_q;
  logic [5:0]  stat_q;
  logic [5:0]  arm_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        rx_irq_q;
  logic        err_irq_q;
  logic        wake_q;

  sci_rx_pkg::rx_state_e state_q;
  logic        rx_q;
  logic [2:0]  hist_q;
  logic [4:0]  rt_q;
  logic [1:0]  samp_q;
  logic [3:0]  bit_idx_q;
  logic [8:0]  shreg_q;
  logic        last_bit_q;
  logic        nz_q;
  logic        done_q;
  logic [8:0]  cdata_q;
  logic        cfe_q;
  logic        cnf_q;
  logic        cpe_q;

  logic        acc;
  logic        wr;
  logic        rd;
  logic        clr_ok;
  logic [5:0]  clr;
  logic        maj;
  logic        dis;
  logic [3:0]  nb;
  logic [8:0]  frame;
  logic        msb;
  logic        receiver_standby_bit;
  logic        wake_mark;
  logic        take;
  logic        load;
  logic        ovr;
  logic        idle_wake;
  logic        idle_set;
  logic        mapped;
  logic [31:0] rdval;
  logic        rx_req;
  logic        err_req;

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign rx_irq      = rx_irq_q;
  assign err_irq     = err_irq_q;
  assign wait_wakeup = wake_q;

  assign lnk.baud_div = baud_q;
  assign lnk.halt     = stop_mode | ~ctrl2_q[sci_rx_pkg::C2_RE];
  assign lnk.nine_bit = ctrl1_q[sci_rx_pkg::C1_NINE];
  assign lnk.idle_count_start_bit     = ctrl1_q[sci_rx_pkg::C1_IDLE_COUNT_START_BIT];
  assign lnk.busy     = (state_q != sci_rx_pkg::ST_HUNT);
  assign lnk.rx_level = rx_q;

  rx_slot_gen u_slot (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (lnk)
  );

  // ==========================================================================
  // apb decode
  assign acc    = psel & penable & pready_q;
  assign wr     = acc & pwrite & ~pslverr_q;
  assign rd     = acc & ~pwrite & ~pslverr_q;
  assign mapped = (paddr == sci_rx_pkg::OFF_CTRL1) | (paddr == sci_rx_pkg::OFF_CTRL2) |
                  (paddr == sci_rx_pkg::OFF_CTRL3) | (paddr == sci_rx_pkg::OFF_STAT1) |
                  (paddr == sci_rx_pkg::OFF_DATA)  | (paddr == sci_rx_pkg::OFF_BRKCTL) |
                  (paddr == sci_rx_pkg::OFF_BAUD);

  always_comb begin
    rdval = 32'h0000_0000;
    case (paddr)
      sci_rx_pkg::OFF_CTRL1:  rdval[4:0] = ctrl1_q;
      sci_rx_pkg::OFF_CTRL2:  rdval[3:0] = ctrl2_q;
      sci_rx_pkg::OFF_CTRL3:  rdval[7:0] = {r8_q, 3'b000, ctrl3_q};
      sci_rx_pkg::OFF_STAT1:  rdval[5:0] = stat_q;
      sci_rx_pkg::OFF_DATA:   rdval[7:0] = data_q;
      sci_rx_pkg::OFF_BRKCTL: rdval[0]   = bce_q;
      sci_rx_pkg::OFF_BAUD:   rdval[15:0] = baud_q;
      default:                rdval = 32'h0000_0000;
    endcase
  end

  // registers closed in wait mode: access answered with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & (wait_mode | ~mapped);
      if (psel & ~penable & ~pwrite & ~wait_mode) begin
        prdata_q <= rdval;
      end else if (acc) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= sci_rx_pkg::CTRL1_RST;
      ctrl3_q <= sci_rx_pkg::CTRL3_RST;
      bce_q   <= 1'b0;
      baud_q  <= sci_rx_pkg::BAUD_RST;
    end else if (wr) begin
      if (paddr == sci_rx_pkg::OFF_CTRL1)  ctrl1_q <= pwdata[4:0];
      if (paddr == sci_rx_pkg::OFF_CTRL3)  ctrl3_q <= pwdata[3:0];
      if (paddr == sci_rx_pkg::OFF_BRKCTL) bce_q   <= pwdata[sci_rx_pkg::BK_BCE];
      if (paddr == sci_rx_pkg::OFF_BAUD)   baud_q  <= pwdata[15:0];
    end
  end

  // standby bit: software write wins, so a mismatched address re-enters standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_q <= sci_rx_pkg::CTRL2_RST;
    end else if (wr && paddr == sci_rx_pkg::OFF_CTRL2) begin
      ctrl2_q <= pwdata[3:0];
    end else if (wake_mark | idle_wake) begin
      ctrl2_q[sci_rx_pkg::C2_RWU] <= 1'b0;
    end
  end

  // ==========================================================================
  // receive engine: slot counter, start check, bit recovery
  assign nb  = ctrl1_q[sci_rx_pkg::C1_NINE] ? 4'd9 : 4'd8;
  assign maj = (samp_q[1] & samp_q[0]) | (samp_q[1] & rx_q) | (samp_q[0] & rx_q);
  assign dis = ~((samp_q[1] & samp_q[0] & rx_q) | ~(samp_q[1] | samp_q[0] | rx_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 1'b1;
    end else begin
      rx_q <= rxd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= sci_rx_pkg::ST_HUNT;
      hist_q     <= 3'b000;
      rt_q       <= sci_rx_pkg::RT_FIRST;
      samp_q     <= 2'b00;
      bit_idx_q  <= 4'h0;
      shreg_q    <= 9'h000;
      last_bit_q <= 1'b0;
      nz_q       <= 1'b0;
    end else if (!ctrl2_q[sci_rx_pkg::C2_RE]) begin
      state_q <= sci_rx_pkg::ST_HUNT;
      hist_q  <= 3'b000;
    end else if (lnk.tick) begin
      hist_q <= {hist_q[1:0], rx_q};
      if (rt_q == sci_rx_pkg::RT_S3 || rt_q == sci_rx_pkg::RT_S5 ||
          rt_q == sci_rx_pkg::RT_S8 || rt_q == sci_rx_pkg::RT_S9) begin
        samp_q <= {samp_q[0], rx_q};
      end
      case (state_q)
        sci_rx_pkg::ST_HUNT: begin
          if (!rx_q && hist_q == 3'b111) begin
            state_q <= sci_rx_pkg::ST_START;
            rt_q    <= sci_rx_pkg::RT_AFTER1;
            nz_q    <= 1'b0;
          end
        end
        sci_rx_pkg::ST_START: begin
          rt_q <= rt_q + 5'd1;
          if (rt_q == sci_rx_pkg::RT_S7) begin
            if (maj) begin
              state_q <= sci_rx_pkg::ST_HUNT;
            end else if (samp_q[1] | samp_q[0] | rx_q) begin
              nz_q <= 1'b1;
            end
          end
          if (rt_q == sci_rx_pkg::RT_S10 && (samp_q[1] | samp_q[0] | rx_q)) begin
            nz_q <= 1'b1;
          end
          if (rt_q == sci_rx_pkg::RT_LAST) begin
            state_q    <= sci_rx_pkg::ST_SHIFT;
            rt_q       <= sci_rx_pkg::RT_FIRST;
            bit_idx_q  <= 4'h0;
            last_bit_q <= 1'b0;
          end
        end
        sci_rx_pkg::ST_SHIFT: begin
          if (last_bit_q && hist_q[0] && !rx_q &&
              (rt_q >= sci_rx_pkg::RT_LATE || rt_q <= sci_rx_pkg::RT_S5)) begin
            rt_q <= sci_rx_pkg::RT_AFTER1;
          end else if (rt_q == sci_rx_pkg::RT_LAST) begin
            rt_q <= sci_rx_pkg::RT_FIRST;
          end else begin
            rt_q <= rt_q + 5'd1;
          end
          if (rt_q == sci_rx_pkg::RT_S10) begin
            if (dis) nz_q <= 1'b1;
            last_bit_q <= maj;
            if (bit_idx_q < nb) begin
              shreg_q   <= {maj, shreg_q[8:1]};
              bit_idx_q <= bit_idx_q + 4'h1;
            end else begin
              state_q <= sci_rx_pkg::ST_HUNT;
            end
          end
        end
        default: state_q <= sci_rx_pkg::ST_HUNT;
      endcase
    end
  end

  // ==========================================================================
  // character completion, decided on the stop bit samples
  assign frame = ctrl1_q[sci_rx_pkg::C1_NINE] ? shreg_q : {1'b0, shreg_q[8:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q  <= 1'b0;
      cdata_q <= 9'h000;
      cfe_q   <= 1'b0;
      cnf_q   <= 1'b0;
      cpe_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (ctrl2_q[sci_rx_pkg::C2_RE] && lnk.tick && state_q == sci_rx_pkg::ST_SHIFT &&
          rt_q == sci_rx_pkg::RT_S10 && bit_idx_q == nb) begin
        done_q  <= 1'b1;
        cdata_q <= frame;
        cfe_q   <= ~maj;
        cnf_q   <= nz_q | dis;
        cpe_q   <= ctrl1_q[sci_rx_pkg::C1_PEN] &
                   ((^frame) ^ ctrl1_q[sci_rx_pkg::C1_PTY]);
      end
    end
  end

  // ==========================================================================
  // flag set and two-step clear, guarded in the break state
  assign receiver_standby_bit       = ctrl2_q[sci_rx_pkg::C2_RWU];
  assign msb       = ctrl1_q[sci_rx_pkg::C1_NINE] ? cdata_q[8] : cdata_q[7];
  assign wake_mark = done_q & receiver_standby_bit & ctrl1_q[sci_rx_pkg::C1_WAKE] & msb;
  assign take      = done_q & (~receiver_standby_bit | wake_mark);
  assign clr_ok    = ~break_state | bce_q;
  assign clr       = (rd && paddr == sci_rx_pkg::OFF_DATA && clr_ok) ? arm_q : 6'b000000;
  assign load      = take & ~(stat_q[sci_rx_pkg::S1_FULL] & ~clr[sci_rx_pkg::S1_FULL]);
  assign ovr       = take & stat_q[sci_rx_pkg::S1_FULL] & ~clr[sci_rx_pkg::S1_FULL];
  assign idle_wake = lnk.idle_det & receiver_standby_bit & ~ctrl1_q[sci_rx_pkg::C1_WAKE];
  assign idle_set  = lnk.idle_det & ~receiver_standby_bit;

  // first step: status read arms the flags it saw set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= 6'b000000;
    end else if (rd && paddr == sci_rx_pkg::OFF_STAT1 && clr_ok) begin
      arm_q <= stat_q;
    end else if (rd && paddr == sci_rx_pkg::OFF_DATA && clr_ok) begin
      arm_q <= 6'b000000;
    end
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 6'b000000;
    end else begin
      stat_q[sci_rx_pkg::S1_FULL] <= load | (stat_q[sci_rx_pkg::S1_FULL] &
                                     ~clr[sci_rx_pkg::S1_FULL]);
      stat_q[sci_rx_pkg::S1_FE]   <= (load & cfe_q) | (stat_q[sci_rx_pkg::S1_FE] &
                                     ~clr[sci_rx_pkg::S1_FE]);
      stat_q[sci_rx_pkg::S1_NF]   <= (load & cnf_q) | (stat_q[sci_rx_pkg::S1_NF] &
                                     ~clr[sci_rx_pkg::S1_NF]);
      stat_q[sci_rx_pkg::S1_PE]   <= (load & cpe_q) | (stat_q[sci_rx_pkg::S1_PE] &
                                     ~clr[sci_rx_pkg::S1_PE]);
      stat_q[sci_rx_pkg::S1_OR]   <= ovr | (stat_q[sci_rx_pkg::S1_OR] &
                                     ~clr[sci_rx_pkg::S1_OR]);
      stat_q[sci_rx_pkg::S1_IDLE] <= idle_set | (stat_q[sci_rx_pkg::S1_IDLE] &
                                     ~clr[sci_rx_pkg::S1_IDLE]);
    end
  end

  // old character kept on overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 8'h00;
      r8_q   <= 1'b0;
    end else if (load) begin
      data_q <= cdata_q[7:0];
      r8_q   <= msb;
    end
  end

  // ==========================================================================
  // interrupt requests and wait exit
  assign rx_req  = ~receiver_standby_bit & ((stat_q[sci_rx_pkg::S1_FULL] & ctrl2_q[sci_rx_pkg::C2_RIE]) |
                           (stat_q[sci_rx_pkg::S1_IDLE] & ctrl2_q[sci_rx_pkg::C2_IDLE_IRQ_ENABLE]));
  assign err_req = (stat_q[sci_rx_pkg::S1_OR] & ctrl3_q[sci_rx_pkg::C3_OVERRUN_IRQ_ENABLE]) |
                   (stat_q[sci_rx_pkg::S1_NF] & ctrl3_q[sci_rx_pkg::C3_NOISE_IRQ_ENABLE]) |
                   (stat_q[sci_rx_pkg::S1_FE] & ctrl3_q[sci_rx_pkg::C3_FRAMING_IRQ_ENABLE]) |
                   (stat_q[sci_rx_pkg::S1_PE] & ctrl3_q[sci_rx_pkg::C3_PARITY_IRQ_ENABLE]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_q  <= 1'b0;
      err_irq_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      rx_irq_q  <= rx_req;
      err_irq_q <= err_req;
      wake_q    <= wait_mode & (rx_req | err_req);
    end
  end

endmodule

// *** rtl/sci_rx_pkg.sv ***
// constants, register map and types of the serial receiver status block
//
// Contract
// - no logic 1 at the stop bit position sets the framing error flag
// - framing error flag rises in the same cycle as receive-buffer-full
// - a break character without stop bit also sets framing error
// - one bad stop sample flags noise, more than one flags framing error
// - sample clock resynchronises on each valid falling edge inside a character
// - stop sampled after 9 or 10 bit times of 16 slots plus 10 slots
// - standby bit puts receiver in standby and suppresses receiver interrupts
// - address mark wakeup: msb of 1 clears standby, sets buffer-full
// - idle wakeup: idle character clears standby, sets no idle or full flag
// - idle count start bit picks counting after start or after stop
// - buffer-full sets on data transfer, gated by its enable to interrupt
// - idle flag after 10 or 11 ones, gated by idle enable
// - overrun keeps old character, drops new, gated to error interrupt
// - noise in start, data or stop bits sets noise flag, gated enable
// - framing error raises error interrupt only with its enable set
// - parity failure sets parity flag, gated to error interrupt
// - wait mode keeps running, registers closed, enabled request ends wait
// - stop mode halts operation, keeps registers, resumes afterwards
// - break clear enable set: flags may clear in break and stay cleared
// - break clear enable clear: accesses in break leave status untouched
// - second clearing step after the break clears a pre-armed flag
// - sample clock runs sixteen slots per bit time
// - stop samples at slots 8, 9, 10 decide framing and noise
package sci_rx_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_CTRL3  = 8'h08;
  localparam logic [7:0] OFF_STAT1  = 8'h0c;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_BRKCTL = 8'h14;
  localparam logic [7:0] OFF_BAUD   = 8'h18;

  // ==========================================================================
  // field positions
  localparam int unsigned C1_NINE = 0;
  localparam int unsigned C1_WAKE = 1;
  localparam int unsigned C1_IDLE_COUNT_START_BIT = 2;
  localparam int unsigned C1_PEN  = 3;
  localparam int unsigned C1_PTY  = 4;
  localparam int unsigned C2_RE   = 0;
  localparam int unsigned C2_RWU  = 1;
  localparam int unsigned C2_RIE  = 2;
  localparam int unsigned C2_IDLE_IRQ_ENABLE = 3;
  localparam int unsigned C3_OVERRUN_IRQ_ENABLE = 0;
  localparam int unsigned C3_NOISE_IRQ_ENABLE = 1;
  localparam int unsigned C3_FRAMING_IRQ_ENABLE = 2;
  localparam int unsigned C3_PARITY_IRQ_ENABLE = 3;
  localparam int unsigned C3_R8   = 7;
  localparam int unsigned S1_PE   = 0;
  localparam int unsigned S1_FE   = 1;
  localparam int unsigned S1_NF   = 2;
  localparam int unsigned S1_OR   = 3;
  localparam int unsigned S1_IDLE = 4;
  localparam int unsigned S1_FULL = 5;
  localparam int unsigned BK_BCE  = 0;

  // ==========================================================================
  // reset values
  localparam logic [4:0]  CTRL1_RST  = 5'h00;
  localparam logic [3:0]  CTRL2_RST  = 4'h0;
  localparam logic [3:0]  CTRL3_RST  = 4'h0;
  localparam logic [15:0] BAUD_RST   = 16'h006c;

  // ==========================================================================
  // sample slot timing
  localparam logic [4:0] RT_FIRST  = 5'd1;
  localparam logic [4:0] RT_AFTER1 = 5'd2;
  localparam logic [4:0] RT_S3     = 5'd3;
  localparam logic [4:0] RT_S5     = 5'd5;
  localparam logic [4:0] RT_S7     = 5'd7;
  localparam logic [4:0] RT_S8     = 5'd8;
  localparam logic [4:0] RT_S9     = 5'd9;
  localparam logic [4:0] RT_S10    = 5'd10;
  localparam logic [4:0] RT_LATE   = 5'd11;
  localparam logic [4:0] RT_LAST   = 5'd16;
  localparam logic [8:0] IDLE_TICKS_8 = 9'd160;
  localparam logic [8:0] IDLE_TICKS_9 = 9'd176;

  typedef enum logic [2:0] {
    ST_HUNT  = 3'b001,
    ST_START = 3'b010,
    ST_SHIFT = 3'b100
  } rx_state_e;

endpackage

// *** rtl/rx_link_if.sv ***
// carrier between the receive core and its slot clock and idle detector
`timescale 1ns/1ps
interface rx_link_if;
  logic [15:0] baud_div;
  logic        halt;
  logic        nine_bit;
  logic        idle_count_start_bit;
  logic        busy;
  logic        rx_level;
  logic        tick;
  logic        idle_det;

  modport gen  (input baud_div, halt, nine_bit, idle_count_start_bit, busy, rx_level,
                output tick, idle_det);
  modport core (output baud_div, halt, nine_bit, idle_count_start_bit, busy, rx_level,
                input tick, idle_det);
endinterface

// *** rtl/rx_slot_gen.sv ***
// sample slot tick generator and idle line detector
`timescale 1ns/1ps
module rx_slot_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  rx_link_if.gen    lnk
);

  logic [15:0] div_q;
  logic        tick_q;
  logic [8:0]  idle_cnt_q;
  logic        idle_arm_q;
  logic        idle_q;
  logic [8:0]  idle_lim;

  assign lnk.tick     = tick_q;
  assign lnk.idle_det = idle_q;
  assign idle_lim = lnk.nine_bit ? sci_rx_pkg::IDLE_TICKS_9 : sci_rx_pkg::IDLE_TICKS_8;

  // ==========================================================================
  // slot tick, held in stop mode so counts resume where they were
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (lnk.halt) begin
      tick_q <= 1'b0;
    end else if (div_q >= lnk.baud_div - 16'h0001) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================================
  // idle line: ones counted per slot, one pulse per idle stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 9'h000;
      idle_arm_q <= 1'b1;
      idle_q     <= 1'b0;
    end else begin
      idle_q <= 1'b0;
      if (tick_q) begin
        if (!lnk.rx_level) begin
          idle_cnt_q <= 9'h000;
          idle_arm_q <= 1'b1;
        end else if (lnk.idle_count_start_bit && lnk.busy) begin
          idle_cnt_q <= 9'h000;
        end else if (idle_cnt_q < idle_lim) begin
          idle_cnt_q <= idle_cnt_q + 9'h001;
          if (idle_cnt_q == idle_lim - 9'h001 && idle_arm_q) begin
            idle_q     <= 1'b1;
            idle_arm_q <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// *** verif/sci_rx_props.sv ***
// protocol and low power assertions for the serial receiver
`timescale 1ns/1ps
module sci_rx_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        break_state,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        rx_irq,
  input wire logic        err_irq,
  input wire logic        wait_wakeup
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // bus answer
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  answer_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  refuse_pair_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_bus_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  unmapped_refuse_a: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
    else $error("unmapped access accepted");
  // ==========================================================================
  // low power
  wait_refuse_a: assert property (psel && !penable && wait_mode |=> pslverr && prdata == 32'h0)
    else $error("register access open in wait");
  wake_cause_a: assert property (wait_wakeup |-> $past(wait_mode))
    else $error("wakeup outside wait");
  wake_request_a: assert property ($past(wait_mode) && rx_irq && $past(rx_irq) |-> wait_wakeup)
    else $error("enabled request does not end wait");
  stop_hold_a: assert property (stop_mode && $past(stop_mode, 4) && !$past(psel)
    && !$past(psel, 2) |-> $stable(rx_irq) && $stable(err_irq))
    else $error("requests move in stop");
endmodule

bind sci_rx_status sci_rx_props props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rxd, .break_state, .wait_mode, .stop_mode, .rx_irq,
  .err_irq, .wait_wakeup);

// *** verif/uart_tx_model.sv ***
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module uart_tx_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic pclk,
  output logic      rxd
);
  initial rxd = 1'b1;
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge pclk);
  endtask
  // mode 0 stop low, 1 stop high, 2 stop high with one short dip
  task automatic send(input logic [8:0] d, input int nbits, input int mode);
    @(posedge pclk);
    hold(1'b0, BIT_CYC);
    for (int i = 0; i < nbits; i++) begin
      hold(d[i], BIT_CYC);
    end
    if (mode == 2) begin
      hold(1'b1, BIT_CYC / 2);
      hold(1'b0, 2);
      hold(1'b1, BIT_CYC / 2 - 2);
    end else begin
      hold(mode == 1, BIT_CYC);
    end
    rxd <= 1'b1;
  endtask
endmodule

// *** verif/sci_receiver_status_wakeup_test.sv ***
// self-checking bench for the serial receiver status block
`timescale 1ns/1ps
module sci_receiver_status_wakeup_test;
  localparam logic [7:0]  C1   = sci_rx_pkg::OFF_CTRL1;
  localparam logic [7:0]  C2   = sci_rx_pkg::OFF_CTRL2;
  localparam logic [7:0]  C3   = sci_rx_pkg::OFF_CTRL3;
  localparam logic [7:0]  ST   = sci_rx_pkg::OFF_STAT1;
  localparam logic [7:0]  DT   = sci_rx_pkg::OFF_DATA;
  localparam logic [31:0] FULL = 32'h1 << sci_rx_pkg::S1_FULL;
  localparam logic [31:0] FE   = 32'h1 << sci_rx_pkg::S1_FE;
  localparam logic [31:0] NF   = 32'h1 << sci_rx_pkg::S1_NF;
  localparam logic [31:0] OVR  = 32'h1 << sci_rx_pkg::S1_OR;
  localparam logic [31:0] IDL  = 32'h1 << sci_rx_pkg::S1_IDLE;
  localparam logic [31:0] PAR  = 32'h1 << sci_rx_pkg::S1_PE;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic        break_state = 1'b0;
  logic        wait_mode   = 1'b0;
  logic        stop_mode   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        rx_irq;
  logic        err_irq;
  logic        wait_wakeup;
  logic        last_err;
  int          err_count       = 0;
  int          samples_checked = 0;

  sci_rx_status dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .break_state, .wait_mode, .stop_mode, .rx_irq, .err_irq,
    .wait_wakeup);
  uart_tx_model #(.BIT_CYC(32)) tx_u (.pclk, .rxd);

  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================================================
  // bus and compare tasks
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk_word(q, exp);
  endtask
  // ==========================================================================
  // scenarios
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(C2, 32'h0);
    rd(sci_rx_pkg::OFF_BAUD, {16'h0, sci_rx_pkg::BAUD_RST});
    rd(8'h1c, 32'h0);
    chk_bit(last_err, 1'b1);
    wr(sci_rx_pkg::OFF_BAUD, 32'h2);
    wr(C3, 32'hf);
    wr(C2, 32'h5);
    repeat (16) @(posedge pclk);
    tx_u.send(9'h0a5, 8, 1);
    rd(ST, FULL);
    chk_bit(rx_irq, 1'b1);
    rd(DT, 32'ha5);
    rd(ST, 32'h0);
    repeat (420) @(posedge pclk);
    rd(ST, IDL);
    chk_bit(rx_irq, 1'b0);
    rd(DT, 32'ha5);
    tx_u.send(9'h000, 8, 0);
    rd(ST, FULL | FE);
    chk_bit(err_irq, 1'b1);
    wr(C3, 32'hb);
    rd(C3, 32'hb);
    chk_bit(err_irq, 1'b0);
    wr(C3, 32'hf);
    rd(DT, 32'h0);
    tx_u.send(9'h03c, 8, 1);
    tx_u.send(9'h0c3, 8, 1);
    rd(ST, FULL | OVR);
    rd(DT, 32'h3c);
    tx_u.send(9'h055, 8, 2);
    rd(ST, FULL | NF);
    rd(DT, 32'h55);
    wr(C1, 32'h08);
    tx_u.send(9'h001, 8, 1);
    rd(ST, FULL | PAR);
    rd(DT, 32'h01);
    wr(C1, 32'h0);
    wr(C2, 32'h7);
    tx_u.send(9'h00f, 8, 1);
    rd(ST, 32'h0);
    repeat (420) @(posedge pclk);
    rd(C2, 32'h5);
    rd(ST, 32'h0);
    wr(C1, 32'h02);
    wr(C2, 32'h7);
    tx_u.send(9'h012, 8, 1);
    rd(ST, 32'h0);
    tx_u.send(9'h092, 8, 1);
    rd(C2, 32'h5);
    rd(ST, FULL);
    chk_bit(rx_irq, 1'b1);
    wr(C2, 32'h7);
    rd(C2, 32'h7);
    chk_bit(rx_irq, 1'b0);
    rd(DT, 32'h92);
    wr(C1, 32'h0);
    wr(C2, 32'h5);
    tx_u.send(9'h011, 8, 1);
    rd(ST, FULL);
    break_state <= 1'b1;
    rd(DT, 32'h11);
    rd(ST, FULL);
    break_state <= 1'b0;
    rd(DT, 32'h11);
    rd(ST, 32'h0);
    tx_u.send(9'h022, 8, 1);
    wr(sci_rx_pkg::OFF_BRKCTL, 32'h1);
    break_state <= 1'b1;
    rd(ST, FULL);
    rd(DT, 32'h22);
    break_state <= 1'b0;
    rd(ST, 32'h0);
    wr(C1, 32'h1);
    tx_u.send(9'h1a5, 9, 1);
    rd(ST, FULL);
    rd(C3, 32'h8f);
    rd(DT, 32'ha5);
    wr(C1, 32'h0);
    tx_u.send(9'h033, 8, 1);
    wait_mode <= 1'b1;
    rd(ST, 32'h0);
    chk_bit(last_err, 1'b1);
    chk_bit(wait_wakeup, 1'b1);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (400) @(posedge pclk);
    stop_mode <= 1'b0;
    rd(ST, FULL);
    rd(DT, 32'h33);
    complete_run();
  end

  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
